// *** hdl/canceller_settings_if.sv ***
// interface: one canceller's settings and detector decisions
`timescale 1ns/1ps
interface canceller_settings_if;
  logic [7:0] path_change_sensitivity;
  logic [15:0] doubletalk_threshold;
  logic signed [15:0] erle_excursion;
  logic signed [15:0] echo_level;
  logic path_change;
  logic doubletalk;
  modport bank (output path_change_sensitivity, output doubletalk_threshold,
    output erle_excursion, output echo_level, input path_change, input doubletalk);
  modport detector (input path_change_sensitivity, input doubletalk_threshold,
    input erle_excursion, input echo_level, output path_change, output doubletalk);
endinterface

// *** hdl/echo_path_doubletalk_thresholds.sv ***
// module: per-group threshold register bank with axi4-lite slave and detectors
`timescale 1ns/1ps
// What this block does
// - each canceller has its own 8-bit read/write sensitivity, reset 41 hex
// - sensitivity is the negative erle margin used by the path change detector
// - larger sensitivity needs larger negative erle excursion to declare change
// - double-talk threshold per canceller, 16-bit two's complement in two bytes
// - threshold is the high-level double-talk detection threshold
// - threshold resets to 4800 hex, high 48 and low 00
// - largest valid threshold 7fff; larger positive values are not to be written
module echo_path_doubletalk_thresholds (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [thresholds_pkg::addr_width-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [thresholds_pkg::addr_width-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic signed [15:0] erle_excursion_a,
  input wire logic signed [15:0] echo_level_a,
  input wire logic signed [15:0] erle_excursion_b,
  input wire logic signed [15:0] echo_level_b,
  output logic path_change_a,
  output logic doubletalk_a,
  output logic path_change_b,
  output logic doubletalk_b
);
  // ------------------------------------------------------------
  // register storage, index 0 is canceller a, 1 is canceller b
  // ------------------------------------------------------------
  logic [7:0] sens_reg [2];
  logic [7:0] dt_low_reg [2];
  logic [7:0] dt_high_reg [2];
  logic [1:0] path_change_v;
  logic [1:0] doubletalk_v;

  // ------------------------------------------------------------
  // write channel
  // ------------------------------------------------------------
  logic [thresholds_pkg::addr_width-1:0] awaddr_reg;
  logic aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_held_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic aw_take;
  logic w_take;
  logic wr_go;
  logic [7:0] wr_idx;
  logic wr_aligned;
  logic wr_lane0;
  logic wr_hit_sens_a;
  logic wr_hit_sens_b;
  logic wr_hit_low_a;
  logic wr_hit_low_b;
  logic wr_hit_high_a;
  logic wr_hit_high_b;
  logic wr_mapped;
  logic [7:0] wr_byte;

  assign aw_take = s_axi_awvalid && awready_reg;
  assign w_take = s_axi_wvalid && wready_reg;
  // address and data may arrive in either order; both are held until the response
  assign wr_go = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_idx = awaddr_reg[9:2];
  assign wr_aligned = awaddr_reg[1:0] == 2'b00;
  assign wr_lane0 = wstrb_reg[0];
  assign wr_byte = wdata_reg[7:0];
  assign wr_hit_sens_a = wr_aligned && wr_idx == thresholds_pkg::idx_path_change_sensitivity_a;
  assign wr_hit_sens_b = wr_aligned && wr_idx == thresholds_pkg::idx_path_change_sensitivity_b;
  assign wr_hit_low_a = wr_aligned && wr_idx == thresholds_pkg::idx_doubletalk_threshold_low_a;
  assign wr_hit_low_b = wr_aligned && wr_idx == thresholds_pkg::idx_doubletalk_threshold_low_b;
  assign wr_hit_high_a = wr_aligned && wr_idx == thresholds_pkg::idx_doubletalk_threshold_high_a;
  assign wr_hit_high_b = wr_aligned && wr_idx == thresholds_pkg::idx_doubletalk_threshold_high_b;
  // the status word is read only, so a write to it is refused
  assign wr_mapped = wr_hit_sens_a || wr_hit_sens_b || wr_hit_low_a || wr_hit_low_b
    || wr_hit_high_a || wr_hit_high_b;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_reg <= '0;
      aw_held_reg <= 1'b0;
      awready_reg <= 1'b0;
    end else if (aw_take) begin
      awaddr_reg <= s_axi_awaddr;
      aw_held_reg <= 1'b1;
      awready_reg <= 1'b0;
    end else if (wr_go) begin
      aw_held_reg <= 1'b0;
    end else begin
      awready_reg <= !aw_held_reg && !bvalid_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdata_reg <= '0;
      wstrb_reg <= '0;
      w_held_reg <= 1'b0;
      wready_reg <= 1'b0;
    end else if (w_take) begin
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
      w_held_reg <= 1'b1;
      wready_reg <= 1'b0;
    end else if (wr_go) begin
      w_held_reg <= 1'b0;
    end else begin
      wready_reg <= !w_held_reg && !bvalid_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= thresholds_pkg::resp_okay;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? thresholds_pkg::resp_okay : thresholds_pkg::resp_slverr;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // setting registers, one generate arm per canceller
  // ------------------------------------------------------------
  logic [1:0] we_sens;
  logic [1:0] we_low;
  logic [1:0] we_high;
  assign we_sens = {wr_hit_sens_b, wr_hit_sens_a} & {2{wr_go && wr_lane0}};
  assign we_low = {wr_hit_low_b, wr_hit_low_a} & {2{wr_go && wr_lane0}};
  assign we_high = {wr_hit_high_b, wr_hit_high_a} & {2{wr_go && wr_lane0}};

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_canc
      canceller_settings_if cs ();
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sens_reg[c] <= thresholds_pkg::sensitivity_reset;
          dt_low_reg[c] <= thresholds_pkg::threshold_low_reset;
          dt_high_reg[c] <= thresholds_pkg::threshold_high_reset;
        end else begin
          if (we_sens[c]) begin
            sens_reg[c] <= wr_byte;
          end
          // each byte only on its own address, the other byte is untouched
          if (we_low[c]) begin
            dt_low_reg[c] <= wr_byte;
          end
          if (we_high[c]) begin
            dt_high_reg[c] <= wr_byte;
          end
        end
      end
      assign cs.path_change_sensitivity = sens_reg[c];
      // stored as written; values above the maximum are the writer's fault
      assign cs.doubletalk_threshold = {dt_high_reg[c], dt_low_reg[c]};
      assign cs.erle_excursion = (c == 0) ? erle_excursion_a : erle_excursion_b;
      assign cs.echo_level = (c == 0) ? echo_level_a : echo_level_b;
      assign path_change_v[c] = cs.path_change;
      assign doubletalk_v[c] = cs.doubletalk;
      threshold_detector u_det (
        .aclk(aclk),
        .aresetn(aresetn),
        .s(cs.detector)
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic ar_take;
  logic [7:0] rd_idx;
  logic rd_aligned;
  logic [3:0] status_word;
  logic [31:0] rd_word;
  logic rd_mapped;

  assign ar_take = s_axi_arvalid && arready_reg;
  assign rd_idx = s_axi_araddr[9:2];
  assign rd_aligned = s_axi_araddr[1:0] == 2'b00;
  assign status_word = {doubletalk_v[1], path_change_v[1], doubletalk_v[0], path_change_v[0]};
  assign rd_mapped = rd_aligned && (rd_idx == thresholds_pkg::idx_path_change_sensitivity_a
    || rd_idx == thresholds_pkg::idx_path_change_sensitivity_b
    || rd_idx == thresholds_pkg::idx_doubletalk_threshold_low_a
    || rd_idx == thresholds_pkg::idx_doubletalk_threshold_low_b
    || rd_idx == thresholds_pkg::idx_doubletalk_threshold_high_a
    || rd_idx == thresholds_pkg::idx_doubletalk_threshold_high_b
    || rd_idx == thresholds_pkg::idx_detector_status);

  always_comb begin
    rd_word = 32'h0000_0000;
    if (rd_aligned) begin
      unique case (rd_idx)
        thresholds_pkg::idx_path_change_sensitivity_a: rd_word[7:0] = sens_reg[0];
        thresholds_pkg::idx_path_change_sensitivity_b: rd_word[7:0] = sens_reg[1];
        thresholds_pkg::idx_doubletalk_threshold_low_a: rd_word[7:0] = dt_low_reg[0];
        thresholds_pkg::idx_doubletalk_threshold_low_b: rd_word[7:0] = dt_low_reg[1];
        thresholds_pkg::idx_doubletalk_threshold_high_a: rd_word[7:0] = dt_high_reg[0];
        thresholds_pkg::idx_doubletalk_threshold_high_b: rd_word[7:0] = dt_high_reg[1];
        thresholds_pkg::idx_detector_status: rd_word[3:0] = status_word;
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= thresholds_pkg::resp_okay;
    end else if (ar_take) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_mapped ? thresholds_pkg::resp_okay : thresholds_pkg::resp_slverr;
    end else if (rvalid_reg) begin
      rvalid_reg <= !s_axi_rready;
    end else begin
      arready_reg <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // detector outputs, registered again so every output is a flop
  // ------------------------------------------------------------
  logic [3:0] flags_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= 4'h0;
    end else begin
      flags_reg <= status_word;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign path_change_a = flags_reg[thresholds_pkg::stat_path_change_a];
  assign doubletalk_a = flags_reg[thresholds_pkg::stat_doubletalk_a];
  assign path_change_b = flags_reg[thresholds_pkg::stat_path_change_b];
  assign doubletalk_b = flags_reg[thresholds_pkg::stat_doubletalk_b];
endmodule

// *** hdl/threshold_detector.sv ***
// module: path change and double-talk decisions for one canceller
`timescale 1ns/1ps
module threshold_detector (
  input wire logic aclk,
  input wire logic aresetn,
  canceller_settings_if.detector s
);
  logic signed [15:0] neg_margin;
  logic path_hit;
  logic dt_hit;
  logic path_change_reg;
  logic doubletalk_reg;
  // larger sensitivity means a deeper negative excursion is needed
  assign neg_margin = -$signed({8'h00, s.path_change_sensitivity});
  assign path_hit = s.erle_excursion < neg_margin;
  // the threshold is the current high:low concatenation
  assign dt_hit = s.echo_level > $signed(s.doubletalk_threshold);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      path_change_reg <= 1'b0;
      doubletalk_reg <= 1'b0;
    end else begin
      path_change_reg <= path_hit;
      doubletalk_reg <= dt_hit;
    end
  end
  assign s.path_change = path_change_reg;
  assign s.doubletalk = doubletalk_reg;
endmodule

// *** hdl/thresholds_pkg.sv ***
// package: register map, reset values and widths of the threshold register bank
package thresholds_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] idx_path_change_sensitivity_a = 8'h13;
  localparam logic [7:0] idx_doubletalk_threshold_low_a = 8'h14;
  localparam logic [7:0] idx_doubletalk_threshold_high_a = 8'h15;
  localparam logic [7:0] idx_doubletalk_threshold_low_b = 8'h34;
  localparam logic [7:0] idx_path_change_sensitivity_b = 8'h33;
  localparam logic [7:0] idx_doubletalk_threshold_high_b = 8'h35;
  localparam logic [7:0] idx_detector_status = 8'h36;
  localparam int addr_width = 10;
  localparam logic [7:0] sensitivity_reset = 8'h41;
  localparam logic [7:0] threshold_low_reset = 8'h00;
  localparam logic [7:0] threshold_high_reset = 8'h48;
  localparam logic [15:0] threshold_max = 16'h7fff;
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
  // status word fields
  localparam int stat_path_change_a = 0;
  localparam int stat_doubletalk_a = 1;
  localparam int stat_path_change_b = 2;
  localparam int stat_doubletalk_b = 3;
endpackage

// *** testbench/tb.sv ***
// testbench: register access and detector scenarios for the threshold bank
`timescale 1ns/1ps
module tb;
  logic aclk, aresetn;
  logic [thresholds_pkg::addr_width-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic signed [15:0] erle_excursion_a, echo_level_a, erle_excursion_b, echo_level_b;
  logic path_change_a, doubletalk_a, path_change_b, doubletalk_b;
  logic [7:0] regs [6];
  logic [7:0] rst [6];
  int num_errors, checks;
  echo_path_doubletalk_thresholds DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .erle_excursion_a, .echo_level_a,
    .erle_excursion_b, .echo_level_b, .path_change_a, .doubletalk_a, .path_change_b,
    .doubletalk_b);
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic end_of_test();
    if (num_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [9:0] addr_of(input logic [7:0] idx);
    return {idx, 2'h0};
  endfunction
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic rd(input logic [9:0] a);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        rd_data = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic rchk(input int i, input logic [7:0] exp);
    rd(addr_of(regs[i]));
    chk(rd_data, {24'h0, exp});
    chk(resp, 2'h0);
  endtask
  task automatic wb(input int i, input logic [7:0] d);
    wr(addr_of(regs[i]), {24'hc3c3c3, d}, 4'hf);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 6; i++) rchk(i, rst[i]);
  endtask
  task automatic t_rw();
    for (int i = 0; i < 6; i++) wb(i, 8'ha0 + 8'(i));
    for (int i = 0; i < 6; i++) rchk(i, 8'ha0 + 8'(i));
    wr(addr_of(regs[1]), 32'h111111ee, 4'he);
    rchk(1, 8'ha1);
    wb(2, 8'h7f);
    wb(1, 8'hff);
    rchk(2, 8'h7f);
    rchk(1, 8'hff);
  endtask
  task automatic t_err();
    rd(10'h3fc);
    chk(resp, 2'h2);
    chk(rd_data, 32'h0);
    wr(10'h04d, 32'h55, 4'h1);
    chk(resp, 2'h2);
    wr(addr_of(thresholds_pkg::idx_detector_status), 32'h0f, 4'h1);
    chk(resp, 2'h2);
    rchk(0, 8'ha0);
  endtask
  task automatic settle_chk(input logic got_sel, input logic exp);
    repeat (4) @(posedge aclk);
    chk(got_sel ? doubletalk_a : path_change_a, exp);
  endtask
  task automatic t_detect();
    wb(0, 8'h10);
    erle_excursion_a <= -16'sd16;
    erle_excursion_b <= -16'sd17;
    settle_chk(1'b0, 1'b0);
    chk(path_change_b, 1'b0);
    erle_excursion_a <= -16'sd17;
    settle_chk(1'b0, 1'b1);
    wb(0, 8'h20);
    settle_chk(1'b0, 1'b0);
    wb(3, 8'h10);
    repeat (4) @(posedge aclk);
    chk(path_change_b, 1'b1);
    // software sets the expected smallest echo level, never above the positive maximum
    wb(2, 8'h48);
    wb(1, 8'h00);
    echo_level_a <= 16'sh4800;
    settle_chk(1'b1, 1'b0);
    echo_level_a <= 16'sh4801;
    settle_chk(1'b1, 1'b1);
    wb(1, 8'h10);
    settle_chk(1'b1, 1'b0);
    echo_level_a <= 16'sh8000;
    settle_chk(1'b1, 1'b0);
    // high byte a5 makes the b threshold negative, so silence already exceeds it
    chk(doubletalk_b, 1'b1);
  endtask
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    #100000;
    num_errors++;
    end_of_test();
  end
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {erle_excursion_a, echo_level_a, erle_excursion_b, echo_level_b} = '0;
    regs = '{thresholds_pkg::idx_path_change_sensitivity_a,
      thresholds_pkg::idx_doubletalk_threshold_low_a, thresholds_pkg::idx_doubletalk_threshold_high_a,
      thresholds_pkg::idx_path_change_sensitivity_b,
      thresholds_pkg::idx_doubletalk_threshold_low_b, thresholds_pkg::idx_doubletalk_threshold_high_b};
    rst = '{8'h41, 8'h00, 8'h48, 8'h41, 8'h00, 8'h48};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_rw();
    t_err();
    t_detect();
    end_of_test();
  end
endmodule

// *** testbench/thresholds_monitor.sv ***
// checker: bus handshakes and canceller a's detector outputs at the bank's ports
`timescale 1ns/1ps
module thresholds_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [thresholds_pkg::addr_width-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic signed [15:0] erle_excursion_a,
  input wire logic signed [15:0] echo_level_a,
  input wire logic path_change_a,
  input wire logic doubletalk_a
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // the pair is stored at the take's edge and answered at the next, so the answer is seen two edges later
  write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  unaligned_err_a: assert property ((wr_taken ##0 s_axi_awaddr[1:0] != 2'h0)
    |-> ##2 s_axi_bvalid && s_axi_bresp == 2'h2) else $error("unaligned write accepted");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  byte_wide_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  // a non-negative excursion can never pass any unsigned margin
  no_change_a: assert property ($past(erle_excursion_a, 2) >= 0 |-> !path_change_a)
    else $error("path change without loss");
  quiet_floor_a: assert property ($past(echo_level_a, 2) == 16'sh8000 |-> !doubletalk_a)
    else $error("double-talk at floor level");
endmodule
bind echo_path_doubletalk_thresholds thresholds_monitor mon (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .erle_excursion_a, .echo_level_a, .path_change_a, .doubletalk_a);
